//--- core/paof_pkg.sv
// Purpose: Shared constants for the port alternate-function override block
// Assumes: 32-bit APB, one register per aligned word, byte address = index * 4
// Notes:   Indices are kept as printed; byte addresses are derived from them

// ==========================================================================
// Package
package paof_pkg;

    // Register indices
    localparam logic [7:0] PAOF_IDX_B_DIR = 8'h04;
    localparam logic [7:0] PAOF_IDX_B_LATCH = 8'h05;
    localparam logic [7:0] PAOF_IDX_D_DIR = 8'h0A;
    localparam logic [7:0] PAOF_IDX_D_LATCH = 8'h0B;
    localparam logic [7:0] PAOF_IDX_E_DIR = 8'h0D;
    localparam logic [7:0] PAOF_IDX_E_LATCH = 8'h0E;
    localparam logic [7:0] PAOF_IDX_SYS_CTL = 8'h35;
    localparam logic [7:0] PAOF_IDX_IRQ_STAT = 8'h40;
    localparam logic [7:0] PAOF_IDX_IRQ_MASK = 8'h41;
    localparam logic [7:0] PAOF_IDX_DIN_DIS = 8'h42;
    localparam logic [7:0] PAOF_IDX_PIN_STATE = 8'h43;

    // Byte addresses on the bus
    localparam logic [9:0] PAOF_ADDR_B_DIR = {PAOF_IDX_B_DIR, 2'b00};
    localparam logic [9:0] PAOF_ADDR_B_LATCH = {PAOF_IDX_B_LATCH, 2'b00};
    localparam logic [9:0] PAOF_ADDR_D_DIR = {PAOF_IDX_D_DIR, 2'b00};
    localparam logic [9:0] PAOF_ADDR_D_LATCH = {PAOF_IDX_D_LATCH, 2'b00};
    localparam logic [9:0] PAOF_ADDR_E_DIR = {PAOF_IDX_E_DIR, 2'b00};
    localparam logic [9:0] PAOF_ADDR_E_LATCH = {PAOF_IDX_E_LATCH, 2'b00};
    localparam logic [9:0] PAOF_ADDR_SYS_CTL = {PAOF_IDX_SYS_CTL, 2'b00};
    localparam logic [9:0] PAOF_ADDR_IRQ_STAT = {PAOF_IDX_IRQ_STAT, 2'b00};
    localparam logic [9:0] PAOF_ADDR_IRQ_MASK = {PAOF_IDX_IRQ_MASK, 2'b00};
    localparam logic [9:0] PAOF_ADDR_DIN_DIS = {PAOF_IDX_DIN_DIS, 2'b00};
    localparam logic [9:0] PAOF_ADDR_PIN_STATE = {PAOF_IDX_PIN_STATE, 2'b00};

    // Field positions and masks
    localparam int PAOF_SYS_PULLUP_DIS_BIT = 4;
    localparam logic [7:0] PAOF_SYS_CTL_RW_MASK = 8'h73;
    localparam int PAOF_DIN_DIS_CHAN6_BIT = 0;
    localparam int PAOF_DIN_DIS_CHAN7_BIT = 1;
    localparam int PAOF_IRQ_W = 5;

    // Reset values
    localparam logic [7:0] PAOF_RST_BYTE = 8'h00;
    localparam logic [31:0] PAOF_RST_WORD = 32'h0000_0000;

endpackage : paof_pkg

//--- core/paof_port_override.sv
// Purpose: Alternate-function override of port D and E pins, with APB registers for ports B, D and E
// Assumes: Single 100 MHz clock; peripherals are outside and talk over plain ports
// Notes:   Pin inputs pass a three-stage filter before any peripheral sees them
//
// Added by the designer: the APB slave port.

`timescale 1ns/1ns

// How it works
// - Transmitter enable forces pin D1 out, serial data
// - Receiver enable forces pin D0 to input
// - Receive pin pull-up follows latch, gated by disable
// - Compare B drives D3 only when direction out
// - Pin D3 also carries the PWM waveform
// - D3 feeds irq one, input kept enabled
// - D2 feeds irq zero, input kept enabled
// - D4..D0 are pin-change sources 20..16
// - D4 supplies timer zero count input
// - D4 carries serial clock in synchronous mode, driven only when direction out
// - E0 outputs comparator result, overriding pull-up, direction
// - E3, E2 analog channels, input disable bits
// - E1 is a plain general-purpose pin
// - Global pull-up disable turns off every pull-up
// - Port B latch and direction, eight bits, zero
module paof_port_override
    import paof_pkg::*;
#(
    parameter int ADDR_W = 12
)(
    input wire logic clk,
    input wire logic arst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    // Pins
    input wire logic [7:0] pbIn,
    output logic [7:0] pbOut,
    output logic [7:0] pbOe,
    output logic [7:0] pbPullup,
    input wire logic [7:0] pdIn,
    output logic [7:0] pdOut,
    output logic [7:0] pdOe,
    output logic [7:0] pdPullup,
    input wire logic [3:0] peIn,
    output logic [3:0] peOut,
    output logic [3:0] peOe,
    output logic [3:0] pePullup,
    // Peripheral side
    input wire logic sleepInputGate,
    input wire logic transmitterEnable,
    input wire logic txSerialOut,
    input wire logic receiverEnable,
    input wire logic serialModeSelect,
    input wire logic serialClockOut,
    input wire logic compareBEnable,
    input wire logic compareBWaveOut,
    input wire logic extIrqZeroEnable,
    input wire logic extIrqOneEnable,
    input wire logic pinChangeGroup2Enable,
    input wire logic [4:0] pinChangeMask,
    input wire logic compOutEnable,
    input wire logic compResult,
    output logic rxData,
    output logic serialClockIn,
    output logic timerZeroCountIn,
    output logic extIrqZeroIn,
    output logic extIrqOneIn,
    output logic [4:0] pinChangeSrc,
    output logic [7:0] pdDigIn,
    output logic [3:0] peDigIn
);

    // ======================================================================
    // Elaboration check
    if (ADDR_W < 11)
    begin : g_addr_chk
        $error("ADDR_W must cover the register map");
    end

    localparam int NPIN = 20;

    // ======================================================================
    // Registers
    logic [7:0] bDir_q, bLatch_q, dDir_q, dLatch_q, eDir_q, eLatch_q;
    logic [7:0] sysCtl_q;
    logic [1:0] dinDis_q;
    logic [PAOF_IRQ_W-1:0] irqMask_q, irqStat_q, irqStat_d;
    logic [31:0] prdata_q;
    logic [NPIN-1:0] sync1_q, sync2_q, sync3_q, filt_q;
    logic [4:0] chgPrev_q;

    // Bus decode
    wire [9:0] offs = paddr[9:0];
    wire highZero = (paddr[ADDR_W-1:10] == '0);
    wire selBDir = highZero && (offs == PAOF_ADDR_B_DIR);
    wire selBLatch = highZero && (offs == PAOF_ADDR_B_LATCH);
    wire selDDir = highZero && (offs == PAOF_ADDR_D_DIR);
    wire selDLatch = highZero && (offs == PAOF_ADDR_D_LATCH);
    wire selEDir = highZero && (offs == PAOF_ADDR_E_DIR);
    wire selELatch = highZero && (offs == PAOF_ADDR_E_LATCH);
    wire selSys = highZero && (offs == PAOF_ADDR_SYS_CTL);
    wire selStat = highZero && (offs == PAOF_ADDR_IRQ_STAT);
    wire selMask = highZero && (offs == PAOF_ADDR_IRQ_MASK);
    wire selDis = highZero && (offs == PAOF_ADDR_DIN_DIS);
    wire selPins = highZero && (offs == PAOF_ADDR_PIN_STATE);
    wire hit = selBDir | selBLatch | selDDir | selDLatch | selEDir | selELatch
        | selSys | selStat | selMask | selDis | selPins;
    wire setup = psel && !penable;
    wire access = psel && penable;
    wire wrEn = access && pwrite && hit;
    wire [7:0] wb = pwdata[7:0];

    // Zero-wait slave; unmapped offsets answer with an error
    assign pready = 1'b1;
    assign pslverr = access && !hit;
    assign prdata = prdata_q;

    // Control fields
    wire pullDis = sysCtl_q[PAOF_SYS_PULLUP_DIS_BIT];
    wire chan6Dis = dinDis_q[PAOF_DIN_DIS_CHAN6_BIT];
    wire chan7Dis = dinDis_q[PAOF_DIN_DIS_CHAN7_BIT];

    // ======================================================================
    // Override signals per port (enable, value)
    // transmit pin forced out, carries serial data
    wire [7:0] ddoeD = {6'b00_0000, transmitterEnable, receiverEnable};
    wire [7:0] ddovD = {6'b00_0000, 1'b1, 1'b0};
    // receive pull-up still latch-driven unless globally disabled
    wire [7:0] puoeD = {6'b00_0000, transmitterEnable, receiverEnable};
    wire [7:0] puovD = {6'b00_0000, 1'b0, dLatch_q[0] & ~pullDis};
    // compare B value only, direction stays with software
    // PWM waveform shares the compare B path
    // synchronous mode supplies the serial clock value, direction stays with software
    wire [7:0] pvoeD = {3'b000, serialModeSelect, compareBEnable, 1'b0,
        transmitterEnable, 1'b0};
    wire [7:0] pvovD = {3'b000, serialClockOut, compareBWaveOut, 1'b0,
        txSerialOut, 1'b0};
    wire [4:0] pcHold = pinChangeMask & {5{pinChangeGroup2Enable}};
    wire [7:0] dieoeD = {3'b000, pcHold[4], pcHold[3] | extIrqOneEnable,
        pcHold[2] | extIrqZeroEnable, pcHold[1:0]};
    wire [7:0] dieovD = 8'hFF;

    // comparator output owns pull-up, direction and value of E0
    // E1 has no override at all
    wire [3:0] puoeE = {3'b000, compOutEnable};
    wire [3:0] ddoeE = {3'b000, compOutEnable};
    wire [3:0] ddovE = 4'b0001;
    wire [3:0] pvovE = {3'b000, compResult};
    // analog channels switch off their digital input
    wire [3:0] dieoeE = {chan7Dis, chan6Dis, 2'b00};

    // Gathered as one vector: B in 7:0, D in 15:8, E in 19:16
    wire [NPIN-1:0] puoe = {puoeE, puoeD, 8'h00};
    wire [NPIN-1:0] puov = {4'b0000, puovD, 8'h00};
    wire [NPIN-1:0] ddoe = {ddoeE, ddoeD, 8'h00};
    wire [NPIN-1:0] ddov = {ddovE, ddovD, 8'h00};
    wire [NPIN-1:0] pvoe = {puoeE, pvoeD, 8'h00};
    wire [NPIN-1:0] pvov = {pvovE, pvovD, 8'h00};
    wire [NPIN-1:0] dieoe = {dieoeE, dieoeD, 8'h00};
    wire [NPIN-1:0] dieov = {4'b0000, dieovD, 8'h00};
    wire [NPIN-1:0] ddrAll = {eDir_q[3:0], dDir_q, bDir_q};
    wire [NPIN-1:0] latAll = {eLatch_q[3:0], dLatch_q, bLatch_q};
    wire [NPIN-1:0] pinAll = {peIn, pdIn, pbIn};

    logic [NPIN-1:0] dirEff, outEff, upEff, dieEff;

    // ======================================================================
    // Per-pin resolution
    // any asserted override beats the register setting
    // pull-up disable kills the register-driven pull-ups
    for (genvar g = 0; g < NPIN; g++)
    begin : g_pin
        assign dirEff[g] = ddoe[g] ? ddov[g] : ddrAll[g];
        assign outEff[g] = pvoe[g] ? pvov[g] : latAll[g];
        assign upEff[g] = puoe[g] ? puov[g] : (~ddrAll[g] & latAll[g] & ~pullDis);
        assign dieEff[g] = dieoe[g] ? dieov[g] : ~sleepInputGate;
    end

    assign pbOe = dirEff[7:0];
    assign pdOe = dirEff[15:8];
    assign peOe = dirEff[19:16];
    assign pbOut = outEff[7:0];
    assign pdOut = outEff[15:8];
    assign peOut = outEff[19:16];
    assign pbPullup = upEff[7:0];
    assign pdPullup = upEff[15:8];
    assign pePullup = upEff[19:16];

    // ======================================================================
    // Input filter: a level counts once stages two and three agree
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
            filt_q <= '0;
        end
        else
        begin
            sync1_q <= pinAll;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            filt_q <= (sync2_q & sync3_q) | (filt_q & (sync2_q ^ sync3_q));
        end
    end

    // Disabled inputs read low so a floating analog pin draws no current
    wire [NPIN-1:0] digAll = filt_q & dieEff;
    assign pdDigIn = digAll[15:8];
    assign peDigIn = digAll[19:16];
    assign pinChangeSrc = digAll[12:8];
    assign rxData = digAll[8];
    assign extIrqZeroIn = digAll[10];
    assign extIrqOneIn = digAll[11];
    // timer zero count taken from D4
    assign timerZeroCountIn = digAll[12];
    // serial clock sampled from the pin
    assign serialClockIn = digAll[12];

    // ======================================================================
    // Interrupt status: a change on D4..D0 sets a sticky bit; set beats clear
    wire [4:0] chgEvt = digAll[12:8] ^ chgPrev_q;
    wire [4:0] statClr = (wrEn && selStat) ? wb[4:0] : 5'b0_0000;
    assign irqStat_d = (irqStat_q & ~statClr) | chgEvt;
    assign irq = |(irqStat_q & irqMask_q);

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            irqStat_q <= '0;
            chgPrev_q <= '0;
        end
        else
        begin
            irqStat_q <= irqStat_d;
            chgPrev_q <= digAll[12:8];
        end
    end

    // ======================================================================
    // Register writes at the access edge
    // port B bytes, cleared at reset
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            bDir_q <= PAOF_RST_BYTE;
            bLatch_q <= PAOF_RST_BYTE;
        end
        else
        begin
            if (wrEn && selBDir)
                bDir_q <= wb;
            if (wrEn && selBLatch)
                bLatch_q <= wb;
        end
    end

    // Port D and E control
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            dDir_q <= PAOF_RST_BYTE;
            dLatch_q <= PAOF_RST_BYTE;
            eDir_q <= PAOF_RST_BYTE;
            eLatch_q <= PAOF_RST_BYTE;
        end
        else
        begin
            if (wrEn && selDDir)
                dDir_q <= wb;
            if (wrEn && selDLatch)
                dLatch_q <= wb;
            if (wrEn && selEDir)
                eDir_q <= wb;
            if (wrEn && selELatch)
                eLatch_q <= wb;
        end
    end

    // System control, masks, input disables; read-only bits stay zero
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sysCtl_q <= PAOF_RST_BYTE;
            irqMask_q <= '0;
            dinDis_q <= '0;
        end
        else
        begin
            if (wrEn && selSys)
                sysCtl_q <= wb & PAOF_SYS_CTL_RW_MASK;
            if (wrEn && selMask)
                irqMask_q <= wb[4:0];
            if (wrEn && selDis)
                dinDis_q <= wb[1:0];
        end
    end

    // ======================================================================
    // Read data, captured in the setup cycle so it is a flop in the access cycle
    wire [31:0] rdMux =
        selBDir ? {24'h00_0000, bDir_q} :
        selBLatch ? {24'h00_0000, bLatch_q} :
        selDDir ? {24'h00_0000, dDir_q} :
        selDLatch ? {24'h00_0000, dLatch_q} :
        selEDir ? {24'h00_0000, eDir_q} :
        selELatch ? {24'h00_0000, eLatch_q} :
        selSys ? {24'h00_0000, sysCtl_q} :
        selStat ? {27'h000_0000, irqStat_q} :
        selMask ? {27'h000_0000, irqMask_q} :
        selDis ? {30'h0000_0000, dinDis_q} :
        selPins ? {12'h000, digAll} : PAOF_RST_WORD;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            prdata_q <= PAOF_RST_WORD;
        else if (setup && !pwrite)
            prdata_q <= rdMux;
    end

    // ======================================================================
    // Assertions
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    a_tx_forced_out: assert property (transmitterEnable |-> pdOe[1]
        && pdOut[1] == txSerialOut && !pdPullup[1])
        else $error("transmit pin not driven by transmitter");
    a_rx_forced_in: assert property (receiverEnable && dDir_q[0] |-> !pdOe[0])
        else $error("receive pin not forced to input");
    a_rx_pullup: assert property (receiverEnable |->
        pdPullup[0] == (dLatch_q[0] && !pullDis))
        else $error("receive pin pull-up wrong");
    a_cmpb_dir_gate: assert property (compareBEnable |-> pdOe[3] == dDir_q[3]
        && pdOut[3] == compareBWaveOut)
        else $error("compare B output ignores direction");
    a_irq1_input: assert property (extIrqOneEnable |-> extIrqOneIn == filt_q[11])
        else $error("irq one input path disabled");
    a_irq0_input: assert property (extIrqZeroEnable |-> extIrqZeroIn == filt_q[10])
        else $error("irq zero input path disabled");
    a_pc_src_enable: assert property (pinChangeGroup2Enable |->
        (pinChangeSrc & pinChangeMask) == (filt_q[12:8] & pinChangeMask))
        else $error("pin-change source input disabled");
    a_cmp_out_e0: assert property (compOutEnable |-> peOe[0] && !pePullup[0]
        && peOut[0] == compResult)
        else $error("comparator output not on E0");
    a_chan_disable: assert property (chan7Dis || chan6Dis |->
        (!peDigIn[3] || !chan7Dis) && (!peDigIn[2] || !chan6Dis))
        else $error("analog channel digital input still on");
    a_pullup_off: assert property (wrEn && selSys && wb[PAOF_SYS_PULLUP_DIS_BIT] |=>
        (pbPullup == 8'h00) && (pdPullup == 8'h00) && (pePullup == 4'h0))
        else $error("pull-up survives global disable");
    a_b_latch_wr: assert property (wrEn && selBLatch |=> bLatch_q == $past(wb)
        && pbOut == $past(wb))
        else $error("port B latch write lost");
    a_irq_sticky: assert property (chgEvt[0] |=> irqStat_q[0]
        ##1 (irqStat_q[0] || $past(statClr[0])))
        else $error("pin change event not sticky");

    c_tx_active: cover property (transmitterEnable ##1 !transmitterEnable);
    c_irq_raise: cover property (!irq ##1 irq);
    c_cmp_out: cover property (compOutEnable && compResult);
    c_slv_err: cover property (pslverr);

endmodule : paof_port_override

//--- dv/paof_pin_partner.sv
// Purpose: Board circuitry on the B, D and E pins
// Assumes: No pull-down on the board; the device driver wins over the bench driver on any pin
// Notes:   A floating pin flips each cycle so a stale level never passes
`timescale 1ns/1ns

// ==========================================================================
// Pin partner
module paof_pin_partner (
    input wire logic clk,
    input wire logic [19:0] oe,
    input wire logic [19:0] out,
    input wire logic [19:0] puEn,
    input wire logic [19:0] drvEn,
    input wire logic [19:0] drvVal,
    output logic [19:0] level
);
    logic [19:0] floatQ = 20'h0_0000;

    // Inverse of the last level, seen only while nobody holds the pin
    always @(posedge clk)
    begin
        floatQ <= ~level;
    end

    // Device driver, then board driver, then pull-up, else floating
    assign level = oe & out | ~oe & drvEn & drvVal | ~oe & ~drvEn & (puEn | floatQ);
endmodule : paof_pin_partner

//--- dv/tb.sv
// Purpose: Self-checking bench for the port alternate-function override
// Assumes: APB slave answers through pready; pin filter settles within 8 edges
// Notes:   Driver queues expected words; a monitor retires one per result
`timescale 1ns/1ns

`define CMP(e, a) begin nCompared++; if ((a) !== (e)) begin errTotal++; \
    $display("mismatch t=%0t exp=%h act=%h", $time, e, a); end end

// ==========================================================================
// Bench top
module tb
    import paof_pkg::*;
;
    logic clk = 1'h0;
    logic arst_n;
    logic psel, penable, pwrite, pready, pslverr, irq, snap, t, c;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, view, expHead;
    logic [7:0] pbIn, pbOut, pbOe, pbPullup, pdIn, pdOut, pdOe, pdPullup, pdDigIn, r;
    logic [3:0] peIn, peOut, peOe, pePullup, peDigIn;
    logic [4:0] pinChangeMask, pinChangeSrc;
    logic [19:0] xEn, xVal, pinLevel;
    logic [1:0] viewSel;
    logic sleepInputGate, transmitterEnable, txSerialOut, receiverEnable, serialModeSelect;
    logic serialClockOut, compareBEnable, compareBWaveOut, extIrqZeroEnable, extIrqOneEnable;
    logic pinChangeGroup2Enable, compOutEnable, compResult, rxData, serialClockIn;
    logic timerZeroCountIn, extIrqZeroIn, extIrqOneIn;
    logic [31:0] expQ[$];
    int errTotal = 0;
    int nCompared = 0;
    logic errExp = 1'h0;
    integer seed = 32'h0000_D6E1;

    // 100 MHz clock
    always #5 clk = ~clk;

    assign pbIn = pinLevel[7:0];
    assign pdIn = pinLevel[15:8];
    assign peIn = pinLevel[19:16];

    paof_port_override paof_port_override_inst (
        .clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .irq, .pbIn, .pbOut, .pbOe, .pbPullup, .pdIn, .pdOut, .pdOe, .pdPullup,
        .peIn, .peOut, .peOe, .pePullup, .sleepInputGate, .transmitterEnable, .txSerialOut,
        .receiverEnable, .serialModeSelect, .serialClockOut, .compareBEnable,
        .compareBWaveOut, .extIrqZeroEnable, .extIrqOneEnable, .pinChangeGroup2Enable,
        .pinChangeMask, .compOutEnable, .compResult, .rxData, .serialClockIn,
        .timerZeroCountIn, .extIrqZeroIn, .extIrqOneIn, .pinChangeSrc, .pdDigIn, .peDigIn
    );

    paof_pin_partner paof_pin_partner_inst (
        .clk, .oe({peOe, pdOe, pbOe}), .out({peOut, pdOut, pbOut}),
        .puEn({pePullup, pdPullup, pbPullup}), .drvEn(xEn), .drvVal(xVal), .level(pinLevel)
    );

    // Output snapshots: B pins, D pins, E pins, peripheral inputs
    always_comb
    begin
        case (viewSel)
            2'h0: view = {8'h00, pbPullup, pbOe, pbOut};
            2'h1: view = {pdPullup, pdOe, pdOut, 8'h00};
            2'h2: view = {20'h0_0000, pePullup, peOe, peOut};
            default: view = {9'h000, peDigIn, irq, rxData, serialClockIn, timerZeroCountIn,
                extIrqZeroIn, extIrqOneIn, pinChangeSrc, pdDigIn};
        endcase
    end

    // Monitor: each read beat or snapshot retires the oldest note
    always @(posedge clk)
    begin
        if (snap || (psel && penable && pready === 1'h1 && !pwrite))
        begin
            expHead = expQ.pop_front();
            `CMP(expHead, (snap ? view : prdata))
        end
        // Error response only for offsets outside the map
        if (psel && penable && pready === 1'h1)
            `CMP(errExp, pslverr)
    end

    // Peripheral-input snapshot from pin levels p and digital inputs d
    function automatic logic [31:0] inView(input logic [3:0] e, input logic i,
        input logic [7:0] p, input logic [7:0] d);
        return {9'h000, e, i, p[0], p[4], p[4], p[2], p[3], p[4:0], d};
    endfunction : inView

    // ==========================================================================
    // Bus and check tasks
    task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= {2'h0, a};
        pwdata <= d;
        errExp <= !(a inside {PAOF_ADDR_B_DIR, PAOF_ADDR_B_LATCH, PAOF_ADDR_D_DIR,
            PAOF_ADDR_D_LATCH, PAOF_ADDR_E_DIR, PAOF_ADDR_E_LATCH, PAOF_ADDR_SYS_CTL,
            PAOF_ADDR_IRQ_STAT, PAOF_ADDR_IRQ_MASK, PAOF_ADDR_DIN_DIS, PAOF_ADDR_PIN_STATE});
        @(posedge clk);
        penable <= 1'h1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'h1 && n < 64);
        // A slave that never answers ends the run as a failure
        if (n >= 64)
        begin
            errTotal++;
            conclude();
        end
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask : wr

    task automatic rd(input logic [9:0] a, input logic [31:0] e);
        expQ.push_back(e);
        apb(1'h0, a, 32'h0000_0000);
    endtask : rd

    task automatic look(input logic [1:0] sel, input logic [31:0] e);
        @(posedge clk);
        viewSel <= sel;
        snap <= 1'h1;
        expQ.push_back(e);
        @(posedge clk);
        snap <= 1'h0;
    endtask : look

    task automatic settle();
        repeat (8) @(posedge clk);
    endtask : settle

    task automatic conclude();
        $display("compared %0d mismatches %0d", nCompared, errTotal);
        if (errTotal == 0 && nCompared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : conclude

    // Watchdog: the tests need under 2000 cycles
    initial
    begin
        repeat (20000) @(posedge clk);
        errTotal++;
        conclude();
    end

    // ==========================================================================
    // Main sequence
    initial
    begin
        {psel, penable, pwrite, snap, sleepInputGate, transmitterEnable, txSerialOut} = '0;
        {receiverEnable, serialModeSelect, serialClockOut, compareBEnable, compareBWaveOut} = '0;
        {extIrqZeroEnable, extIrqOneEnable, pinChangeGroup2Enable, compOutEnable} = '0;
        {compResult, pinChangeMask, viewSel, paddr, pwdata} = '0;
        xEn = 20'hF_FFFF;
        xVal = 20'h0_0000;
        arst_n = 1'h0;
        repeat (3) @(posedge clk);
        arst_n <= 1'h1;
        rd(PAOF_ADDR_B_DIR, PAOF_RST_WORD);
        rd(PAOF_ADDR_B_LATCH, PAOF_RST_WORD);
        rd(PAOF_ADDR_SYS_CTL, PAOF_RST_WORD);
        r = 8'($random(seed));
        wr(PAOF_ADDR_B_DIR, {24'h00_0000, r});
        wr(PAOF_ADDR_B_LATCH, {24'h00_0000, ~r});
        rd(PAOF_ADDR_B_DIR, {24'h00_0000, r});
        rd(PAOF_ADDR_B_LATCH, {24'h00_0000, ~r});
        wr(PAOF_ADDR_SYS_CTL, 32'hFFFF_FFFF);
        rd(PAOF_ADDR_SYS_CTL, {24'h00_0000, PAOF_SYS_CTL_RW_MASK});
        look(2'h0, {8'h00, 8'h00, r, ~r});
        wr(PAOF_ADDR_SYS_CTL, 32'h0000_0000);
        look(2'h0, {8'h00, ~r, r, ~r});
        rd(10'h3FC, 32'h0000_0000);
        $display("test registers done");
        r = 8'($random(seed));
        wr(PAOF_ADDR_D_DIR, 32'h0000_0001);
        wr(PAOF_ADDR_D_LATCH, 32'h0000_0001);
        transmitterEnable <= 1'h1;
        receiverEnable <= 1'h1;
        txSerialOut <= r[0];
        look(2'h1, {8'h01, 8'h02, 6'h00, r[0], 1'h1, 8'h00});
        wr(PAOF_ADDR_SYS_CTL, 32'h0000_0010);
        look(2'h1, {8'h00, 8'h02, 6'h00, r[0], 1'h1, 8'h00});
        wr(PAOF_ADDR_SYS_CTL, 32'h0000_0000);
        transmitterEnable <= 1'h0;
        receiverEnable <= 1'h0;
        $display("test serial pins done");
        // waveform and serial clock on D3, D4
        r = 8'($random(seed));
        t = r[0];
        c = r[1];
        compareBEnable <= 1'h1;
        compareBWaveOut <= t;
        serialModeSelect <= 1'h1;
        serialClockOut <= c;
        wr(PAOF_ADDR_D_DIR, 32'h0000_0000);
        look(2'h1, {8'h01, 8'h00, 3'h0, c, t, 3'h1, 8'h00});
        wr(PAOF_ADDR_D_DIR, 32'h0000_0018);
        look(2'h1, {8'h01, 8'h18, 3'h0, c, t, 3'h1, 8'h00});
        compareBEnable <= 1'h0;
        serialModeSelect <= 1'h0;
        wr(PAOF_ADDR_D_DIR, 32'h0000_0000);
        wr(PAOF_ADDR_D_LATCH, 32'h0000_0000);
        $display("test waveform pins done");
        wr(PAOF_ADDR_E_DIR, 32'h0000_0002);
        wr(PAOF_ADDR_E_LATCH, 32'h0000_0003);
        compOutEnable <= 1'h1;
        compResult <= t;
        look(2'h2, {20'h0_0000, 4'h0, 4'h3, 3'h1, t});
        compOutEnable <= 1'h0;
        look(2'h2, {20'h0_0000, 4'h1, 4'h2, 4'h3});
        wr(PAOF_ADDR_E_DIR, 32'h0000_0000);
        $display("test port e done");
        // gated inputs follow only enabled sources
        r = 8'($random(seed));
        wr(PAOF_ADDR_B_DIR, 32'h0000_0000);
        xVal <= {4'hF, r, 8'h5A};
        sleepInputGate <= 1'h1;
        settle();
        look(2'h3, 32'h0000_0000);
        extIrqZeroEnable <= 1'h1;
        extIrqOneEnable <= 1'h1;
        pinChangeGroup2Enable <= 1'h1;
        pinChangeMask <= 5'h13;
        settle();
        look(2'h3, inView(4'h0, 1'h0, r, {3'h0, r[4:0]}));
        sleepInputGate <= 1'h0;
        // channel disable bits drop E2, E3 inputs
        for (int k = 0; k < 4; k++)
        begin
            wr(PAOF_ADDR_DIN_DIS, 32'(k));
            settle();
            rd(PAOF_ADDR_PIN_STATE, {12'h000, ~k[1], ~k[0], 2'h3, r, 8'h5A});
        end
        $display("test inputs done");
        // pin changes raise, mask and clear the interrupt
        wr(PAOF_ADDR_IRQ_STAT, 32'h0000_001F);
        rd(PAOF_ADDR_IRQ_STAT, 32'h0000_0000);
        xVal <= {4'hF, ~r, 8'h5A};
        settle();
        rd(PAOF_ADDR_IRQ_STAT, 32'h0000_001F);
        look(2'h3, inView(4'h3, 1'h0, ~r, ~r));
        wr(PAOF_ADDR_IRQ_MASK, 32'h0000_001F);
        look(2'h3, inView(4'h3, 1'h1, ~r, ~r));
        wr(PAOF_ADDR_IRQ_STAT, 32'h0000_001F);
        look(2'h3, inView(4'h3, 1'h0, ~r, ~r));
        $display("test interrupt done");
        conclude();
    end
endmodule : tb
